// File: hw/cie_defs.svh
/*
  Constants of the core interrupt enable and priority block: register
  addresses, bit positions of the seven sources and reset values.
  Assumes inclusion by bare name from files under hw/.
*/
`ifndef CIE_DEFS_SVH
`define CIE_DEFS_SVH

// ==========================================================
// register addresses, also the base of their bit addresses
`define CIE_ADDR_ENABLE 8'ha8
`define CIE_ADDR_LEVEL 8'hb8

// ==========================================================
// source positions in both registers
`define CIE_SRC_EXT0 3'h0
`define CIE_SRC_TMR0 3'h1
`define CIE_SRC_EXT1 3'h2
`define CIE_SRC_TMR1 3'h3
`define CIE_SRC_UART 3'h4
`define CIE_SRC_TMR2 3'h5
`define CIE_SRC_SPI 3'h6
`define CIE_BIT_GLOBAL 3'h7

// ==========================================================
// reset values and fixed read values
`define CIE_ENABLE_RST 8'h00
`define CIE_LEVEL_RST 7'h00
`define CIE_LEVEL_TOP_RD 1'h1
`define CIE_UNMAPPED_RD 8'h00

`endif

// File: hw/cie_pkg.sv
/*
  Types of the core interrupt enable and priority block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cie_pkg;

  // hold-off sequencer after a return from service
  typedef enum logic [1:0] {
    CIE_ST_RUN = 2'b01,
    CIE_ST_WAIT = 2'b10
  } cie_hold_state_t;

  typedef logic [6:0] cie_src_vec_t;

endpackage : cie_pkg

// File: hw/cie_cfg_if.sv
/*
  Carrier of the register contents from the register file to the
  gating logic. Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface cie_cfg_if;
  logic [7:0] enable;
  logic [6:0] level;

  modport regs (output enable, output level);
  modport user (input enable, input level);
endinterface : cie_cfg_if

`default_nettype wire

// File: hw/cie_sync2.sv
/*
  Two-stage synchroniser for a group of asynchronous levels.
  Assumes the inputs come from pins outside the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module cie_sync2 #(
  parameter int WIDTH = 2
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  // ==========================================================
  // first stage is read only by the second
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      stage1 <= '0;
      stage2 <= '0;
    end
    else
    begin
      stage1 <= async_i;
      stage2 <= stage1;
    end
  end

  assign sync_o = stage2;

endmodule : cie_sync2

`default_nettype wire

// File: hw/cie_regs.sv
/*
  Enable and level registers with byte and single-bit write access.
  Assumes writes arrive as one-cycle strobes on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cie_defs.svh"

module cie_regs
  import cie_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] bit_addr_i,
  input wire logic bit_wr_i,
  input wire logic bit_wdata_i,
  cie_cfg_if.regs cfg
);

  localparam logic [7:0] ADDR_EN = `CIE_ADDR_ENABLE;
  localparam logic [7:0] ADDR_LV = `CIE_ADDR_LEVEL;

  logic [7:0] enable;
  logic [6:0] level;
  logic [7:0] next_enable;
  logic [6:0] next_level;

  // ==========================================================
  // byte write wins over a bit write in the same cycle
  always_comb
  begin
    next_enable = enable;
    next_level = level;
    if (sfr_wr_i && sfr_addr_i == ADDR_EN)
      next_enable = sfr_wdata_i; // [R10]
    else if (bit_wr_i && bit_addr_i[7:3] == ADDR_EN[7:3])
      next_enable[bit_addr_i[2:0]] = bit_wdata_i; // [R10]
    if (sfr_wr_i && sfr_addr_i == ADDR_LV)
      next_level = sfr_wdata_i[6:0]; // [R15]
    else if (bit_wr_i && bit_addr_i[7:3] == ADDR_LV[7:3] && bit_addr_i[2:0] != `CIE_BIT_GLOBAL)
      next_level[bit_addr_i[2:0]] = bit_wdata_i; // [R16]
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      enable <= `CIE_ENABLE_RST; // [R10]
      level <= `CIE_LEVEL_RST; // [R14]
    end
    else
    begin
      enable <= next_enable;
      level <= next_level;
    end
  end

  assign cfg.enable = enable;
  assign cfg.level = level;

endmodule : cie_regs

`default_nettype wire

// File: hw/cie_top.sv
/*
  Core interrupt enable and priority block: global and per-source
  enables, per-source priority level, request gating, priority resolve
  and hold-off while a routine of equal or higher level is in service.
  Assumes peripheral pending flags and core strobes on clk_i; the two
  external interrupt inputs are asynchronous pins.
*/
// Behaviour
// [R1] Global enable bit 7 clear blocks every request regardless of the masks.
// [R2] Global enable set passes a request only when its own mask bit is set.
// [R3] Enable bit 6 gates the serial peripheral interface request.
// [R4] Enable bit 5 gates timer 2; either overflow flag raises it.
// [R5] Enable bit 4 gates the first serial port request.
// [R6] Enable bit 3 gates the timer 1 overflow request.
// [R7] Enable bit 2 gates external interrupt input 1.
// [R8] Enable bit 1 gates the timer 0 overflow request.
// [R9] Enable bit 0 gates external interrupt input 0.
// [R10] Enable register at 0xa8, all pages, bit access, resets to zero.
// [R11] Level bit 2 sets the external input 1 priority.
// [R12] Level bit 1 sets the timer 0 priority.
// [R13] Level bit 0 means low priority, 1 means high priority.
// [R14] Level bits 6,5,4,3,0 serve spi, timer 2, uart, timer 1, ext 0.
// [R15] Level bit 7 unused: reads 1, writes ignored.
// [R16] Level register reachable on all pages with single-bit access.
// [R17] Pending requests sampled and priority resolved every clock.
// [R18] Equal or higher level in service holds off until return plus one instruction.
`timescale 1ns/1ps
`default_nettype none
`include "cie_defs.svh"

module cie_top
  import cie_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic [7:0] bit_addr_i,
  input wire logic bit_wr_i,
  input wire logic bit_wdata_i,
  input wire logic bit_rd_i,
  output logic bit_rdata_o,
  input wire logic ext_irq_input_zero_i,
  input wire logic ext_irq_input_one_i,
  input wire logic timer0_overflow_flag_i,
  input wire logic timer1_overflow_flag_i,
  input wire logic timer2_low_overflow_flag_i,
  input wire logic timer2_high_overflow_flag_i,
  input wire logic first_serial_port_irq_i,
  input wire logic serial_periph_port_irq_i,
  input wire logic vector_taken_i,
  input wire logic reti_i,
  input wire logic instr_done_i,
  output logic [6:0] masked_req_o,
  output logic [6:0] req_level_o,
  output logic irq_req_o,
  output logic [2:0] irq_src_o,
  output logic irq_high_o,
  output logic [1:0] in_service_o
);

  localparam logic [7:0] ADDR_EN = `CIE_ADDR_ENABLE;
  localparam logic [7:0] ADDR_LV = `CIE_ADDR_LEVEL;

  cie_cfg_if cfg ();

  logic [1:0] ext_sync;
  cie_src_vec_t raw;
  cie_src_vec_t masked_now;
  cie_src_vec_t hi_req;
  cie_src_vec_t lo_req;
  logic [7:0] level_rd;

  // ==========================================================
  // registers and pin synchronisers
  cie_regs u_regs (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i),
    .sfr_wdata_i(sfr_wdata_i),
    .bit_addr_i(bit_addr_i),
    .bit_wr_i(bit_wr_i),
    .bit_wdata_i(bit_wdata_i),
    .cfg(cfg.regs)
  );

  cie_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .async_i({ext_irq_input_one_i, ext_irq_input_zero_i}),
    .sync_o(ext_sync)
  );

  // ==========================================================
  // raw requests in source order
  always_comb
  begin
    raw = '0;
    raw[`CIE_SRC_EXT0] = ext_sync[0];
    raw[`CIE_SRC_TMR0] = timer0_overflow_flag_i;
    raw[`CIE_SRC_EXT1] = ext_sync[1];
    raw[`CIE_SRC_TMR1] = timer1_overflow_flag_i;
    raw[`CIE_SRC_UART] = first_serial_port_irq_i;
    raw[`CIE_SRC_TMR2] = timer2_low_overflow_flag_i | timer2_high_overflow_flag_i; // [R4]
    raw[`CIE_SRC_SPI] = serial_periph_port_irq_i;
  end

  // ==========================================================
  // per-source gating and level split
  for (genvar g = 0; g < 7; g++)
  begin : g_src
    // [R1] [R2] [R3] [R5] [R6] [R7] [R8] [R9]
    assign masked_now[g] = cfg.enable[`CIE_BIT_GLOBAL] & cfg.enable[g] & raw[g];
    assign hi_req[g] = masked_now[g] & cfg.level[g]; // [R13]
    assign lo_req[g] = masked_now[g] & ~cfg.level[g]; // [R13]
  end

  // lowest source index wins within a level
  function automatic logic [2:0] first_set(input cie_src_vec_t v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 6; i >= 0; i--)
    begin
      if (v[i])
        idx = 3'(i);
    end
    return idx;
  endfunction : first_set

  // ==========================================================
  // hold-off sequencer and resolved request
  cie_hold_state_t hold_state;
  cie_hold_state_t next_hold_state;
  logic isv_low;
  logic isv_high;
  logic next_isv_low;
  logic next_isv_high;
  logic next_irq_req;
  logic [2:0] next_irq_src;
  logic next_irq_high;
  cie_src_vec_t next_masked;
  cie_src_vec_t next_req_level;

  always_comb
  begin
    next_hold_state = hold_state;
    next_isv_low = isv_low;
    next_isv_high = isv_high;
    unique case (hold_state)
      CIE_ST_RUN:
      begin
        if (reti_i)
        begin
          if (isv_high)
            next_isv_high = 1'b0;
          else
            next_isv_low = 1'b0;
          next_hold_state = CIE_ST_WAIT; // [R18]
        end
      end
      CIE_ST_WAIT:
      begin
        if (instr_done_i)
          next_hold_state = CIE_ST_RUN; // [R18]
      end
      default:
      begin
        next_hold_state = CIE_ST_RUN;
      end
    endcase
    if (vector_taken_i)
    begin
      if (irq_high_o)
        next_isv_high = 1'b1;
      else
        next_isv_low = 1'b1;
    end
  end

  always_comb
  begin
    next_masked = masked_now; // [R17]
    next_req_level = hi_req; // [R11] [R12] [R14]
    next_irq_req = 1'b0;
    next_irq_src = 3'h0;
    next_irq_high = 1'b0;
    if (hold_state == CIE_ST_RUN && next_hold_state == CIE_ST_RUN)
    begin
      if (|hi_req && !next_isv_high)
      begin
        next_irq_req = 1'b1; // [R17]
        next_irq_src = first_set(hi_req);
        next_irq_high = 1'b1;
      end
      else if (|lo_req && !next_isv_high && !next_isv_low)
      begin
        next_irq_req = 1'b1; // [R18]
        next_irq_src = first_set(lo_req);
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      hold_state <= CIE_ST_RUN;
      isv_low <= 1'b0;
      isv_high <= 1'b0;
      irq_req_o <= 1'b0;
      irq_src_o <= 3'h0;
      irq_high_o <= 1'b0;
      masked_req_o <= '0;
      req_level_o <= '0;
      in_service_o <= 2'h0;
    end
    else
    begin
      hold_state <= next_hold_state;
      isv_low <= next_isv_low;
      isv_high <= next_isv_high;
      irq_req_o <= next_irq_req;
      irq_src_o <= next_irq_src;
      irq_high_o <= next_irq_high;
      masked_req_o <= next_masked;
      req_level_o <= next_req_level;
      in_service_o <= {next_isv_high, next_isv_low};
    end
  end

  // ==========================================================
  // registered read port, byte and single bit
  logic [7:0] next_sfr_rdata;
  logic next_bit_rdata;

  assign level_rd = {`CIE_LEVEL_TOP_RD, cfg.level}; // [R15]

  always_comb
  begin
    next_sfr_rdata = sfr_rdata_o;
    next_bit_rdata = bit_rdata_o;
    if (sfr_rd_i)
    begin
      if (sfr_addr_i == ADDR_EN)
        next_sfr_rdata = cfg.enable;
      else if (sfr_addr_i == ADDR_LV)
        next_sfr_rdata = level_rd; // [R15]
      else
        next_sfr_rdata = `CIE_UNMAPPED_RD;
    end
    if (bit_rd_i)
    begin
      if (bit_addr_i[7:3] == ADDR_EN[7:3])
        next_bit_rdata = cfg.enable[bit_addr_i[2:0]]; // [R10]
      else if (bit_addr_i[7:3] == ADDR_LV[7:3])
        next_bit_rdata = level_rd[bit_addr_i[2:0]]; // [R16]
      else
        next_bit_rdata = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sfr_rdata_o <= 8'h00;
      bit_rdata_o <= 1'b0;
    end
    else
    begin
      sfr_rdata_o <= next_sfr_rdata;
      bit_rdata_o <= next_bit_rdata;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_reti_in_run;
    hold_state == CIE_ST_RUN && reti_i;
  endsequence

  sequence s_instr_after;
    hold_state == CIE_ST_WAIT && instr_done_i;
  endsequence

  a_global_block: assert property (!cfg.enable[7] |=> masked_req_o == 7'h00) // [R1]
    else $error("request passed with global enable clear");

  a_mask_gates: assert property (cfg.enable[7] && !cfg.enable[0] |=> !masked_req_o[0]) // [R2]
    else $error("masked source 0 passed");

  a_spi_pass: assert property ( // [R3]
    cfg.enable[7] && cfg.enable[6] && serial_periph_port_irq_i |=> masked_req_o[6])
    else $error("spi request not passed");

  a_tmr2_either: assert property (cfg.enable[7] && cfg.enable[5] // [R4]
    && (timer2_low_overflow_flag_i || timer2_high_overflow_flag_i) |=> masked_req_o[5])
    else $error("timer 2 flag did not raise request");

  a_uart_block: assert property (!cfg.enable[4] |=> !masked_req_o[4]) // [R5]
    else $error("uart request passed while disabled");

  a_tmr1_pass: assert property ( // [R6]
    cfg.enable[7] && cfg.enable[3] && timer1_overflow_flag_i |=> masked_req_o[3])
    else $error("timer 1 request not passed");

  a_enable_bitwr: assert property (bit_wr_i && !sfr_wr_i && bit_addr_i == 8'had // [R10]
    |=> cfg.enable[5] == $past(bit_wdata_i))
    else $error("enable bit write lost");

  a_level_tag: assert property (masked_req_o[2] |-> req_level_o[2] == $past(cfg.level[2])) // [R11]
    else $error("ext 1 level tag wrong");

  a_tmr0_level: assert property (masked_req_o[1] && !req_level_o[1] && irq_req_o // [R12]
    && masked_req_o[0] == 1'b0 |-> irq_high_o || irq_src_o == 3'h1)
    else $error("timer 0 low request mis-resolved");

  a_level_top: assert property (sfr_rd_i && sfr_addr_i == 8'hb8 |=> sfr_rdata_o[7]) // [R15]
    else $error("unused level bit read as zero");

  a_sample_each: assert property (hold_state == CIE_ST_RUN && !reti_i && !isv_high // [R17]
    && !vector_taken_i && |hi_req |=> irq_req_o && irq_high_o)
    else $error("high request not presented next cycle");

  a_hold_high: assert property (isv_high && !reti_i |=> !irq_req_o) // [R18]
    else $error("request presented over high routine");

  a_reti_wait: assert property (s_reti_in_run |=> !irq_req_o ##0 hold_state == CIE_ST_WAIT) // [R18]
    else $error("no hold after return");

  a_wait_end: assert property (s_instr_after |=> hold_state == CIE_ST_RUN ##0 !irq_req_o) // [R18]
    else $error("hold not ended by one instruction");

endmodule : cie_top

`default_nettype wire

// File: bench/cie_core_model.sv
/*
  Behavioural core sequencer: takes a presented request, runs a routine,
  returns, then finishes one instruction.
  Assumes the bench gates it with svc_en_i and that strobes act on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module cie_core_model (
  input wire logic clk_i,
  input wire logic svc_en_i,
  input wire logic irq_req_i,
  input wire logic [4:0] hold_i,
  output logic vector_taken_o,
  output logic reti_o,
  output logic instr_done_o
);
  // ==========================================================
  // one service per presented request while allowed
  initial
  begin
    vector_taken_o = 1'b0;
    reti_o = 1'b0;
    instr_done_o = 1'b0;
    forever
    begin
      @(negedge clk_i);
      if (svc_en_i && irq_req_i)
      begin
        vector_taken_o = 1'b1;
        @(negedge clk_i);
        vector_taken_o = 1'b0;
        repeat (hold_i) @(negedge clk_i);
        reti_o = 1'b1;
        @(negedge clk_i);
        reti_o = 1'b0;
        // slow instruction after the return
        repeat (hold_i) @(negedge clk_i);
        instr_done_o = 1'b1;
        @(negedge clk_i);
        instr_done_o = 1'b0;
      end
    end
  end
endmodule : cie_core_model

`default_nettype wire

// File: bench/test_cie_top.sv
/*
  Self-checking bench of the interrupt enable and priority block.
  Assumes cie_top and the core sequencer model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module test_cie_top;
  logic clk_i, arst_n_i, sfr_wr_i, sfr_rd_i, bit_wr_i, bit_wdata_i, bit_rd_i, bit_rdata_o;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, bit_addr_i, r, en, lv;
  logic [6:0] masked_req_o, req_level_o;
  logic irq_req_o, irq_high_o, svc_en, vtk, reti, idn;
  logic [2:0] irq_src_o;
  logic [1:0] in_service_o;
  logic [4:0] hold;
  int failures, samples_checked, cycles, busy;

  cie_top dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o), .bit_addr_i(bit_addr_i), .bit_wr_i(bit_wr_i),
    .bit_wdata_i(bit_wdata_i), .bit_rd_i(bit_rd_i), .bit_rdata_o(bit_rdata_o),
    .ext_irq_input_zero_i(r[0]), .timer0_overflow_flag_i(r[1]), .ext_irq_input_one_i(r[2]),
    .timer1_overflow_flag_i(r[3]), .first_serial_port_irq_i(r[4]),
    .timer2_low_overflow_flag_i(r[5]), .timer2_high_overflow_flag_i(r[6]),
    .serial_periph_port_irq_i(r[7]), .vector_taken_i(vtk), .reti_i(reti),
    .instr_done_i(idn), .masked_req_o(masked_req_o), .req_level_o(req_level_o),
    .irq_req_o(irq_req_o), .irq_src_o(irq_src_o), .irq_high_o(irq_high_o),
    .in_service_o(in_service_o));

  cie_core_model core (.clk_i(clk_i), .svc_en_i(svc_en), .irq_req_i(irq_req_o),
    .hold_i(hold), .vector_taken_o(vtk), .reti_o(reti), .instr_done_o(idn));

  // ==========================================================
  // clock and hang guard
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      stop_test();
    end
  end

  // ==========================================================
  // compares, bus cycles, expectations
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic chk1(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask : chk1

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge clk_i);
    sfr_wr_i = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge clk_i);
    sfr_rd_i = 1'b0;
    chk({24'h0, sfr_rdata_o}, {24'h0, e});
  endtask : rd

  task automatic bwr(input logic [7:0] a, input logic d);
    @(negedge clk_i);
    bit_addr_i = a;
    bit_wdata_i = d;
    bit_wr_i = 1'b1;
    @(negedge clk_i);
    bit_wr_i = 1'b0;
  endtask : bwr

  task automatic brd(input logic [7:0] a, input logic e);
    @(negedge clk_i);
    bit_addr_i = a;
    bit_rd_i = 1'b1;
    @(negedge clk_i);
    bit_rd_i = 1'b0;
    chk1(bit_rdata_o, e);
  endtask : brd

  // {masked, tagged high, request, high, source}
  function automatic logic [31:0] expect_out(input logic [7:0] e, l, raw);
    logic [6:0] m;
    logic [6:0] h;
    logic [6:0] p;
    logic [2:0] s;
    m = e[7] ? e[6:0] & {raw[7], raw[6] | raw[5], raw[4:0]} : 7'h00;
    h = m & l[6:0];
    p = (|h) ? h : m;
    s = 3'h0;
    for (int i = 6; i >= 0; i--)
      if (p[i]) s = 3'(i);
    return {13'h0, m, h, |m, |h, s};
  endfunction : expect_out

  task automatic stop_test();
    if (failures == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(7187));
    {arst_n_i, sfr_wr_i, sfr_rd_i, bit_wr_i, bit_rd_i, bit_wdata_i, svc_en} = '0;
    {sfr_addr_i, sfr_wdata_i, bit_addr_i, r, en, lv} = '0;
    hold = 5'd20;
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (12) @(negedge clk_i);
    arst_n_i = 1'b1;
    rd(8'ha8, 8'h00);
    rd(8'hb8, 8'h80);
    wr(8'hb8, 8'hff);
    rd(8'hb8, 8'hff);
    wr(8'hb8, 8'h00);
    rd(8'hb8, 8'h80);
    for (int i = 0; i < 8; i++)
    begin
      bwr(8'ha8 + 8'(i), 1'b1);
      rd(8'ha8, 8'hff >> (7 - i));
      brd(8'ha8 + 8'(i), 1'b1);
      bwr(8'hb8 + 8'(i), 1'b1);
      rd(8'hb8, 8'h80 | (8'hff >> (7 - i)));
    end
    bwr(8'hbf, 1'b0);
    brd(8'hbf, 1'b1);
    rd(8'h55, 8'h00);
    // gating with corners first: global off, all masks off
    for (int k = 0; k < 40; k++)
    begin
      en = (k == 0) ? 8'h7f : (k == 1) ? 8'h80 : 8'($urandom);
      lv = 8'($urandom);
      wr(8'ha8, en);
      wr(8'hb8, lv);
      r = (k < 2) ? 8'hff : 8'($urandom);
      repeat (4) @(negedge clk_i);
      chk({13'h0, masked_req_o, req_level_o, irq_req_o, irq_high_o, irq_src_o},
        expect_out(en, lv, r));
    end
    // mid-run reset returns both registers to their reset values
    arst_n_i = 1'b0;
    repeat (3) @(negedge clk_i);
    arst_n_i = 1'b1;
    rd(8'ha8, 8'h00);
    rd(8'hb8, 8'h80);
    // hold-off around a low routine
    wr(8'ha8, 8'h8a);
    wr(8'hb8, 8'h00);
    r = 8'h08;
    hold = 5'(20 + $urandom_range(8));
    repeat (3) @(negedge clk_i);
    chk({27'h0, irq_req_o, irq_high_o, irq_src_o}, 32'h13);
    svc_en = 1'b1;
    repeat (10) if (vtk !== 1'b1) @(posedge clk_i);
    @(negedge clk_i);
    svc_en = 1'b0;
    chk({29'h0, in_service_o, irq_req_o}, 32'h2);
    r = 8'h0a;
    bwr(8'hb9, 1'b1);
    repeat (3) @(negedge clk_i);
    chk({27'h0, irq_req_o, irq_high_o, irq_src_o}, 32'h19);
    r = 8'h08;
    repeat (40) if (reti !== 1'b1) @(posedge clk_i);
    busy = 0;
    repeat (40) if (idn !== 1'b1)
    begin
      @(posedge clk_i);
      #1;
      busy += int'(irq_req_o === 1'b1);
    end
    chk(busy, 0);
    @(negedge clk_i);
    chk1(irq_req_o, 1'b0);
    @(negedge clk_i);
    chk({26'h0, in_service_o, irq_req_o, irq_src_o}, 32'h0b);
    // high routine holds off both levels until return plus one instruction
    r = 8'h0a;
    @(negedge clk_i);
    chk({27'h0, irq_req_o, irq_high_o, irq_src_o}, 32'h19);
    svc_en = 1'b1;
    repeat (10) if (vtk !== 1'b1) @(posedge clk_i);
    @(negedge clk_i);
    svc_en = 1'b0;
    chk({29'h0, in_service_o, irq_req_o}, 32'h4);
    busy = 0;
    repeat (40) if (reti !== 1'b1)
    begin
      @(posedge clk_i);
      #1;
      busy += int'(irq_req_o === 1'b1);
    end
    repeat (40) if (idn !== 1'b1)
    begin
      @(posedge clk_i);
      #1;
      busy += int'(irq_req_o === 1'b1);
    end
    chk(busy, 0);
    @(negedge clk_i);
    chk1(irq_req_o, 1'b0);
    @(negedge clk_i);
    chk({25'h0, in_service_o, irq_req_o, irq_high_o, irq_src_o}, 32'h19);
    stop_test();
  end
endmodule : test_cie_top

`default_nettype wire
